// >>> core_voltage_grade_select.sv
// Core voltage grade select: strap capture, grade fetch and select outputs
//
// Functional notes
// - Feature off unless strap enables it
// - Capture enable strap at reset release
// - Enabled: pins become select outputs only
// - Disabled: pins stay general-purpose I/O
// - Grade comes from fixed storage at boot
// - Present fetched grade after reset release
// - Code 00 full voltage, 11 reduced
// - Mirror driven code into read-only status
// - Outputs may be unsettled for 62 us
// - Both select pins carry identical values
`timescale 1ns/1ps
module core_voltage_grade_select #(
  parameter int unsigned SETTLE_CYC = grade_pkg::UNSETTLED_CYC
) (
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   nrst,
  // Strap and permanent grade storage
  input  wire logic                   voltage_adjust_enable_pin,
  input  wire logic                   grade_fuse,
  // General-purpose I/O requests for the shared pair
  input  wire grade_pkg::gpio_drive_t gpio_drv,
  input  wire logic [1:0]             shared_general_io_pair_in,
  // Shared pins
  output      logic [1:0]             shared_general_io_pair_out,
  output      logic [1:0]             shared_general_io_pair_oe_n,
  // Status
  output      logic [7:0]             boot_config_register,
  output      logic [1:0]             voltage_grade_readback,
  output      logic [1:0]             gpio_in_value,
  output      logic                   select_settled
);
  import grade_pkg::*;

  logic [1:0]        strap_sync_ff;
  logic              first_ff;
  logic              en_ff;
  logic [1:0]        code_ff;
  logic [1:0]        nxt_code;
  logic [CNT_W-1:0]  cnt_ff;
  logic [CNT_W-1:0]  nxt_cnt;
  logic [1:0]        gin_s1_ff;
  logic [1:0]        gin_s2_ff;
  logic              grade_s1_ff;
  logic              grade_s2_ff;
  grade_state_t      state_ff;
  grade_state_t      nxt_state;
  pin_drive_t        pin_drv;
  wire               cnt_done = (cnt_ff == CNT_W'(SETTLE_CYC - 1));
  wire  [1:0]        fetched  = (grade_s2_ff == GRADE_STRONG) ? CODE_REDUCED_V : CODE_FULL_V;

  // Strap synchroniser has no reset
  // It must keep sampling while reset is held, or the strap would read as zero at release.
  always_ff @(posedge sys_clk) begin
    strap_sync_ff <= {strap_sync_ff[0], voltage_adjust_enable_pin};
  end

  // Pin and grade synchronisers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      gin_s1_ff     <= 2'h0;
      gin_s2_ff     <= 2'h0;
      grade_s1_ff   <= 1'h0;
      grade_s2_ff   <= 1'h0;
    end else begin
      gin_s1_ff     <= shared_general_io_pair_in;
      gin_s2_ff     <= gin_s1_ff;
      grade_s1_ff   <= grade_fuse;
      grade_s2_ff   <= grade_s1_ff;
    end
  end

  // Latch strap once
  // Caught on the first clock after release; a strap is static, so the synchroniser
  // delay costs nothing. clear until then, so pins stay general purpose.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      first_ff <= 1'h1;
      en_ff    <= 1'h0;
    end else if (first_ff && state_ff == ST_IDLE) begin
      first_ff <= 1'h0;
      en_ff    <= strap_sync_ff[1];
    end
  end

  // Sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_code  = code_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      ST_IDLE: begin
        if (!first_ff && en_ff) begin
          nxt_state = ST_FETCH;
        end
      end
      ST_FETCH: begin
        nxt_state = ST_UNSETTLED;
        nxt_cnt   = '0;
      end
      ST_UNSETTLED: begin
        nxt_code = CODE_FULL_V;
        nxt_cnt  = cnt_ff + CNT_W'(1);
        if (cnt_done) begin
          nxt_state = ST_HOLD;
          nxt_code  = fetched;
        end
      end
      ST_HOLD: begin
        nxt_code = code_ff;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= ST_IDLE;
      code_ff  <= CODE_FULL_V;
      cnt_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      code_ff  <= nxt_code;
      cnt_ff   <= nxt_cnt;
    end
  end

  pin_pair_mux u_mux (
    .sel_mode (en_ff),
    .gpio_drv (gpio_drv),
    .sel_code (code_ff),
    .pin_drv  (pin_drv)
  );

  // Registered outputs
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      shared_general_io_pair_out  <= 2'h0;
      shared_general_io_pair_oe_n <= 2'h3;
      boot_config_register        <= BOOT_CONFIG_REGISTER_RESET;
      voltage_grade_readback      <= CODE_FULL_V;
      gpio_in_value               <= 2'h0;
      select_settled              <= 1'h0;
    end else begin
      shared_general_io_pair_out  <= pin_drv.out_val;
      shared_general_io_pair_oe_n <= pin_drv.oe_n;
      boot_config_register        <= BOOT_CONFIG_REGISTER_RESET | (8'(en_ff) << BOOT_CONFIG_REGISTER_EN_POS);
      voltage_grade_readback      <= en_ff ? pin_drv.out_val : CODE_FULL_V;
      // GPIO input reads zero when the pair is dedicated
      gpio_in_value               <= en_ff ? 2'h0 : gin_s2_ff;
      select_settled              <= (state_ff == ST_HOLD);
    end
  end

  sequence s_enter_wait;
    state_ff == ST_FETCH;
  endsequence

  chk_unsettled_full: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    s_enter_wait |=> (code_ff == CODE_FULL_V) [*8])
    else $error("Code left full voltage during unsettled period");

  chk_pins_equal: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    en_ff |=> (shared_general_io_pair_out[0] == shared_general_io_pair_out[1]))
    else $error("Select pins differ");

  chk_pins_driven: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    en_ff |=> (shared_general_io_pair_oe_n == 2'h0))
    else $error("Select pins not driven");

  chk_gpio_kept: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    !en_ff |=> (shared_general_io_pair_oe_n == $past(gpio_drv.oe_n)))
    else $error("GPIO drive not passed through");

  chk_code_stable: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (state_ff == ST_HOLD) |=> $stable(code_ff))
    else $error("Code changed after settling");

  chk_mirror_match: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    en_ff |=> (voltage_grade_readback == shared_general_io_pair_out))
    else $error("Readback differs from pins");

  chk_code_legal: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (code_ff == CODE_FULL_V) || (code_ff == CODE_REDUCED_V))
    else $error("Illegal select code");

  chk_grade_shown: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (state_ff == ST_UNSETTLED && cnt_done) |=> (code_ff == $past(fetched)))
    else $error("Fetched grade not presented");

  chk_strap_bit: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    $fell(first_ff) |-> (en_ff == $past(strap_sync_ff[1])))
    else $error("Enable strap not captured");

  chk_default_off: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    first_ff |-> !en_ff)
    else $error("Feature on before strap capture");

endmodule : core_voltage_grade_select

// >>> grade_pkg.sv
// Package: constants and carriers for the core voltage grade select block
package grade_pkg;

  localparam int unsigned CLK_HZ          = 40_000_000;
  // Unsettled window after reset release, in microseconds
  localparam int unsigned UNSETTLED_US    = 62;
  localparam int unsigned UNSETTLED_CYC   = (UNSETTLED_US * (CLK_HZ / 1_000_000));
  localparam int unsigned CNT_W           = 12;

  localparam logic [1:0]  CODE_FULL_V     = 2'h0;
  localparam logic [1:0]  CODE_REDUCED_V  = 2'h3;
  localparam logic        GRADE_STRONG    = 1'h1;

  localparam int unsigned BOOT_CONFIG_REGISTER_EN_POS  = 0;
  localparam logic [7:0]  BOOT_CONFIG_REGISTER_RESET   = 8'h00;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FETCH,
    ST_UNSETTLED,
    ST_HOLD
  } grade_state_t;

  // General-purpose drive request for the shared pin pair
  typedef struct packed {
    logic [1:0] out_val;
    logic [1:0] oe_n;
  } gpio_drive_t;

  // Pin-level result for the shared pair
  typedef struct packed {
    logic [1:0] out_val;
    logic [1:0] oe_n;
  } pin_drive_t;

endpackage : grade_pkg

// >>> pin_pair_mux.sv
// Output selection for the shared general-purpose / voltage-select pin pair
`timescale 1ns/1ps
module pin_pair_mux (
  // Mode
  input  wire logic                  sel_mode,
  // Sources
  input  wire grade_pkg::gpio_drive_t gpio_drv,
  input  wire logic [1:0]            sel_code,
  // Result
  output      grade_pkg::pin_drive_t pin_drv
);
  import grade_pkg::*;

  // Select mode always drives both pins; output enable low means driving
  assign pin_drv.out_val = sel_mode ? sel_code : gpio_drv.out_val;
  assign pin_drv.oe_n    = sel_mode ? 2'h0 : gpio_drv.oe_n;

endmodule : pin_pair_mux

// >>> supply_model.sv
// Behavioural adjustable core supply fed by one select pin
`timescale 1ns/1ps
module supply_model #(
  parameter int unsigned GATE = 8
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic nrst,
  // Select pin and resulting supply level
  input  wire logic sel_in,
  output      logic full_v
);
  int unsigned gate_cnt_ff;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      gate_cnt_ff <= 0;
    end else if (gate_cnt_ff < GATE) begin
      gate_cnt_ff <= gate_cnt_ff + 1;
    end
  end
  // Hold full level while gated, then act on one pin
  assign full_v = (gate_cnt_ff < GATE) ? 1'b1 : ~sel_in;
endmodule : supply_model

// >>> tb_top.sv
// Self-checking bench for the core voltage grade select block
`timescale 1ns/1ps
module tb_top;
  import grade_pkg::*;
  localparam int unsigned SC = 8;
  logic        sys_clk, nrst, strap, fuse, settled, full_v;
  gpio_drive_t gdrv;
  logic [1:0]  ext, pout, poe_n, gin, rb;
  logic [7:0]  bcfg;
  int          error_cnt, checked, cyc, i;
  // Pin level from whoever drives each pin
  wire  [1:0]  lvl = (~poe_n & pout) | (poe_n & ext);
  core_voltage_grade_select #(.SETTLE_CYC(SC)) core_voltage_grade_select_i (
    .sys_clk(sys_clk), .nrst(nrst), .voltage_adjust_enable_pin(strap), .grade_fuse(fuse),
    .gpio_drv(gdrv), .shared_general_io_pair_in(lvl), .shared_general_io_pair_out(pout),
    .shared_general_io_pair_oe_n(poe_n), .boot_config_register(bcfg),
    .voltage_grade_readback(rb), .gpio_in_value(gin), .select_settled(settled));
  supply_model #(.GATE(SC)) supply_model_i (
    .sys_clk(sys_clk), .nrst(nrst), .sel_in(lvl[0]), .full_v(full_v));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic wrap_up();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cycles
  // Strap held before release
  // Strap and fuse held stable across the reset, released just after an edge
  task automatic boot(input logic s, input logic f);
    nrst = 1'b0;
    strap = s;
    fuse = f;
    cycles(2);
    nrst = 1'b1;
  endtask : boot
  task automatic wait_settled();
    for (i = 0; i < 40 && settled !== 1'b1; i++) cycles(1);
  endtask : wait_settled
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      wrap_up();
    end
  end
  initial begin
    error_cnt = 0;
    checked = 0;
    cyc = 0;
    gdrv = '{out_val: 2'h2, oe_n: 2'h1};
    ext = 2'h1;
    boot(1'b0, 1'b1);
    cycles(5);
    chk(bcfg, 8'h00);
    chk({pout, poe_n}, 4'h9);
    chk(gin, 2'h3);
    chk(rb, 2'h0);
    chk(full_v, 1'b1);
    gdrv = '{out_val: 2'h3, oe_n: 2'h3};
    boot(1'b1, 1'b0);
    cycles(3);
    chk(bcfg, 8'h01);
    chk({pout, poe_n}, 4'h0);
    strap = 1'b0;
    wait_settled();
    // Settled rises SC+4 edges after release; the wait starts three edges in
    chk(i, SC + 1);
    chk({pout, rb, gin}, 6'h00);
    chk(bcfg, 8'h01);
    chk(full_v, 1'b1);
    boot(1'b1, 1'b1);
    cycles(3);
    chk({pout, full_v}, 3'h1);
    wait_settled();
    chk(i, SC + 1);
    chk({pout, poe_n, rb}, 6'h33);
    fuse = 1'b0;
    strap = 1'b0;
    cycles(20);
    chk({pout, rb}, 4'hf);
    chk(full_v, 1'b0);
    wrap_up();
  end
endmodule : tb_top
